// File: core/qsf_top.v
// Questionable status filter: condition, transition filters, event and parser error
`timescale 1ns/1ps
`include "qsf_regs.vh"

// Functional notes
// - Falling edge with falling filter bit sets event
// - Rising edge with rising filter bit sets event
// - Both filter bits zero never set event
// - Fixed fault to status bit mapping, 15-9 unused
// - Both filters writable and readable; host writes 0-511
// - Error query returns one of five indications
// - Event register read-only, accumulates, stays 0-511
// - Condition register is read-only live fault image
// - Summary set when enabled and event nonzero
module qsf_top #(
  parameter FAULT_W = `QSF_FAULT_W
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_over_voltage_fault,
  input wire i_line_input_fault,
  input wire i_over_current_fault,
  input wire i_fan_fault,
  input wire i_output_short_fault,
  input wire i_over_temp_fault,
  input wire i_over_power_fault,
  input wire i_inner_dcdc_stage_fault,
  input wire i_inner_adc_stage_fault,
  input wire i_cmd_valid,
  input wire [`QSF_CMD_W-1:0] i_cmd_code,
  input wire [`QSF_WORD_W-1:0] i_cmd_data,
  input wire i_err_valid,
  input wire [`QSF_ERR_W-1:0] i_err_code,
  input wire i_ques_srq_enable,
  output reg o_rsp_valid,
  output reg [`QSF_WORD_W-1:0] o_rsp_data,
  output reg o_ques_summary
);

  // Data path in brief:
  // Fault pins gathered into status order
  // Two flops bring them onto the system clock
  // Synchronised image compared with its previous value
  // Each edge masked by its falling or rising filter bit
  // Masked edges collect in the event register until read
  // Parser errors kept apart, one indication at a time
  // Answers leave through one registered response port

  wire [FAULT_W-1:0] fault_raw; // Pins gathered into status order
  // Only the synchroniser's second stage feeds the logic below
  wire [FAULT_W-1:0] cond_live; // Synchronised condition image

  // Edge state resets low, the idle level of the fault pins,
  // so release of reset never shows a false rising edge
  reg [FAULT_W-1:0] cond_prev_reg; // Condition one cycle earlier
  reg [FAULT_W-1:0] fall_filter_reg; // Falling edge filter
  reg [FAULT_W-1:0] fall_filter_next;
  reg [FAULT_W-1:0] rise_filter_reg; // Rising edge filter
  reg [FAULT_W-1:0] rise_filter_next;
  reg [FAULT_W-1:0] event_reg; // Latched events
  reg [FAULT_W-1:0] event_next;
  reg [`QSF_ERR_W-1:0] error_reg; // Pending parser error
  reg [`QSF_ERR_W-1:0] error_next;
  // Response word holds between answers; only the strobe pulses
  reg rsp_valid_next;
  reg [`QSF_WORD_W-1:0] rsp_data_next;
  reg summary_next;

  // One bit per status position, high for a single cycle
  wire [FAULT_W-1:0] fall_hits; // Filtered falling edges
  wire [FAULT_W-1:0] rise_hits; // Filtered rising edges

  // Pad a fault vector into a host word, upper bits read as zero
  // Used by every read that returns a nine-bit value
  function [`QSF_WORD_W-1:0] widen;
    input [FAULT_W-1:0] val;
    begin
      widen = {{(`QSF_WORD_W-FAULT_W){1'b0}}, val};
    end
  endfunction

  // Accept only the four nonzero indications; anything else is an execution error
  // Keeps the query from ever returning a sixth value
  // Zero never reaches here; it means no report
  function [`QSF_ERR_W-1:0] legal_err;
    input [`QSF_ERR_W-1:0] code;
    begin
      case (code)
        `QSF_ERR_FORMAT: legal_err = `QSF_ERR_FORMAT;
        `QSF_ERR_RANGE: legal_err = `QSF_ERR_RANGE;
        `QSF_ERR_TOO_MANY: legal_err = `QSF_ERR_TOO_MANY;
        default: legal_err = `QSF_ERR_EXEC;
      endcase
    end
  endfunction

  // Fault pins placed at their status bit positions
  // Bits 15-9 have no source and read back as zero
  // Pin order is fixed by the status word, not by the port list
  assign fault_raw[`QSF_BIT_OVER_VOLTAGE] = i_over_voltage_fault;
  assign fault_raw[`QSF_BIT_LINE_INPUT] = i_line_input_fault;
  assign fault_raw[`QSF_BIT_OVER_CURRENT] = i_over_current_fault;
  assign fault_raw[`QSF_BIT_FAN_FAIL] = i_fan_fault;
  assign fault_raw[`QSF_BIT_OUTPUT_SHORT] = i_output_short_fault;
  assign fault_raw[`QSF_BIT_OVER_TEMP] = i_over_temp_fault;
  assign fault_raw[`QSF_BIT_OVER_POWER] = i_over_power_fault;
  assign fault_raw[`QSF_BIT_INNER_DCDC] = i_inner_dcdc_stage_fault;
  assign fault_raw[`QSF_BIT_INNER_ADC] = i_inner_adc_stage_fault;

  // Fault pins are asynchronous to the system clock
  // Two cycles of latency on every edge, traded for keeping
  // metastable values out of the edge detector
  qsf_sync #(
    .WIDTH(FAULT_W)
  ) u_fault_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(fault_raw),
    .o_sync(cond_live)
  );

  // Edge detection gated per bit by the two filters
  // Both filter bits clear: no hit in either direction
  // Both set: every change of the condition bit latches
  assign fall_hits = cond_prev_reg & ~cond_live & fall_filter_reg;
  assign rise_hits = ~cond_prev_reg & cond_live & rise_filter_reg;

  // Next-state logic for filters, events, error and response
  always @* begin
    fall_filter_next = fall_filter_reg;
    rise_filter_next = rise_filter_reg;
    event_next = event_reg | fall_hits | rise_hits;
    error_next = error_reg;
    rsp_valid_next = 1'b0;
    // Hold the last answer word; only the strobe drops back
    rsp_data_next = o_rsp_data;
    // One command per cycle; unknown codes fall to the default branch
    if (i_cmd_valid) begin
      case (i_cmd_code)
        // Live image, not latched; a short glitch is not seen here
        `QSF_CMD_READ_COND: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = widen(cond_live);
        end
        `QSF_CMD_READ_EVENT: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = widen(event_reg);
          // Clear on read; edges in this same cycle survive
          event_next = fall_hits | rise_hits;
        end
        `QSF_CMD_WRITE_FALL: begin
          // Upper bits dropped, so out-of-range writes cannot arm unused bits
          fall_filter_next = i_cmd_data[FAULT_W-1:0];
        end
        // Nine stored bits, padded for the host
        `QSF_CMD_READ_FALL: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = widen(fall_filter_reg);
        end
        // Same truncation as the falling filter
        `QSF_CMD_WRITE_RISE: begin
          rise_filter_next = i_cmd_data[FAULT_W-1:0];
        end
        `QSF_CMD_READ_RISE: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = widen(rise_filter_reg);
        end
        // Returns the pending indication and frees the slot
        `QSF_CMD_READ_ERROR: begin
          rsp_valid_next = 1'b1;
          rsp_data_next = {{(`QSF_WORD_W-`QSF_ERR_W){1'b0}}, error_reg};
          error_next = `QSF_ERR_NONE;
        end
        default: begin
          // Unknown codes are ignored, no response
          rsp_valid_next = 1'b0;
        end
      endcase
    end
    // A new parser error wins over the clear of a query in the same cycle
    if (i_err_valid && (i_err_code != `QSF_ERR_NONE)) begin
      if (error_reg == `QSF_ERR_NONE || (i_cmd_valid && i_cmd_code == `QSF_CMD_READ_ERROR)) begin
        error_next = legal_err(i_err_code);
      end else begin
        // Slot already taken, so report the overflow instead
        error_next = `QSF_ERR_TOO_MANY;
      end
    end
    // Built from the next event value, so the summary moves on
    // the same edge as the event register, not a cycle behind
    summary_next = i_ques_srq_enable && (event_next != `QSF_FAULT_RST);
  end

  // State registers; everything returns to zero and no error at reset
  // Reset branch assigns constants only
  // Filters come up disarmed, so no event can latch before setup
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cond_prev_reg <= `QSF_FAULT_RST;
      fall_filter_reg <= `QSF_FAULT_RST;
      rise_filter_reg <= `QSF_FAULT_RST;
      event_reg <= `QSF_FAULT_RST;
      error_reg <= `QSF_ERR_NONE;
      o_rsp_valid <= 1'b0;
      // Answer word reads zero until the first response
      o_rsp_data <= `QSF_WORD_RST;
      o_ques_summary <= 1'b0;
    end else begin
      cond_prev_reg <= cond_live;
      fall_filter_reg <= fall_filter_next;
      rise_filter_reg <= rise_filter_next;
      event_reg <= event_next;
      error_reg <= error_next;
      o_rsp_valid <= rsp_valid_next;
      o_rsp_data <= rsp_data_next;
      o_ques_summary <= summary_next;
    end
  end

  // Limitation: no per-bit mask between events and summary;
  // any nonzero event raises it while requests are enabled

endmodule // qsf_top

// File: core/qsf_regs.vh
// Constants for the questionable status filter block
`ifndef QSF_REGS_VH
`define QSF_REGS_VH

// Width of a status word as seen by the host
`define QSF_WORD_W 16
// Number of live fault bits
`define QSF_FAULT_W 9
// Zero upper bits padding a 9-bit value into a status word
`define QSF_PAD_W 7

// Fault bit positions in the status word
`define QSF_BIT_INNER_ADC 0
`define QSF_BIT_INNER_DCDC 1
`define QSF_BIT_OVER_POWER 2
`define QSF_BIT_OVER_TEMP 3
`define QSF_BIT_OUTPUT_SHORT 4
`define QSF_BIT_FAN_FAIL 5
`define QSF_BIT_OVER_CURRENT 6
`define QSF_BIT_LINE_INPUT 7
`define QSF_BIT_OVER_VOLTAGE 8

// Command codes from the command parser
`define QSF_CMD_W 3
`define QSF_CMD_READ_COND 3'h0
`define QSF_CMD_READ_EVENT 3'h1
`define QSF_CMD_WRITE_FALL 3'h2
`define QSF_CMD_READ_FALL 3'h3
`define QSF_CMD_WRITE_RISE 3'h4
`define QSF_CMD_READ_RISE 3'h5
`define QSF_CMD_READ_ERROR 3'h6

// Parser error indications
`define QSF_ERR_W 3
`define QSF_ERR_NONE 3'h0
`define QSF_ERR_FORMAT 3'h1
`define QSF_ERR_RANGE 3'h2
`define QSF_ERR_TOO_MANY 3'h3
`define QSF_ERR_EXEC 3'h4

// Reset values
`define QSF_FAULT_RST 9'h000
`define QSF_WORD_RST 16'h0000

`endif

// File: core/qsf_sync.v
// Two-flop synchroniser for a bus of independent level inputs
`timescale 1ns/1ps
module qsf_sync #(
  parameter WIDTH = 9
) (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg; // First stage, read only by the second
  reg [WIDTH-1:0] sync_reg; // Second stage, safe to use

  // Each bit is an independent level, so no cross-bit coherence is needed
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // qsf_sync

// File: bench/qsf_top_monitor.sv
// Port-level assertions for the questionable status filter
`timescale 1ns/1ps
module qsf_top_mon (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_cmd_valid,
  input wire [2:0] i_cmd_code,
  input wire [15:0] i_cmd_data,
  input wire i_err_valid,
  input wire [2:0] i_err_code,
  input wire i_ques_srq_enable,
  input wire o_rsp_valid,
  input wire [15:0] o_rsp_data,
  input wire o_ques_summary
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Commands that expect an answer word
  wire rd_cmd = i_cmd_valid && (i_cmd_code inside {3'h0, 3'h1, 3'h3, 3'h5, 3'h6});
  sequence s_wr_fall; i_cmd_valid && i_cmd_code == 3'h2; endsequence
  sequence s_rd_fall; i_cmd_valid && i_cmd_code == 3'h3; endsequence
  sequence s_query; i_cmd_valid && i_cmd_code == 3'h6; endsequence
  // Error report that does not coincide with a query
  sequence s_err; i_err_valid && i_err_code != 3'h0 && !(i_cmd_valid && i_cmd_code == 3'h6); endsequence
  AST_READ_ANSWER: assert property (rd_cmd |=> o_rsp_valid)
    else $error("read command got no answer");
  AST_NO_ANSWER: assert property (!rd_cmd |=> !o_rsp_valid)
    else $error("answer without a read command");
  AST_UPPER_ZERO: assert property (o_rsp_valid |-> o_rsp_data[15:9] == 7'h00)
    else $error("unused answer bits set");
  AST_FILTER_READBACK: assert property (s_wr_fall ##1 s_rd_fall |=> o_rsp_data == ($past(i_cmd_data, 2) & 16'h01FF))
    else $error("falling filter readback wrong");
  AST_ERR_CODE_RANGE: assert property (s_query |=> o_rsp_data <= 16'h0004)
    else $error("error answer out of range");
  AST_ERR_CLEARS: assert property (s_query ##0 !i_err_valid ##1 s_query |=> o_rsp_data == 16'h0000)
    else $error("error not cleared by query");
  AST_SUMMARY_OFF: assert property (!i_ques_srq_enable |=> !o_ques_summary)
    else $error("summary set while disabled");
  AST_TOO_MANY: assert property (s_err ##1 s_err ##1 s_query |=> o_rsp_data == 16'h0003)
    else $error("second error not reported as overflow");
endmodule // qsf_top_mon
bind qsf_top qsf_top_mon i_qsf_top_mon (.*);

// File: bench/qsf_host.sv
// Host model issuing parser commands and error reports
`timescale 1ns/1ps
module qsf_host (
  input wire i_sys_clk,
  output reg o_cmd_valid,
  output reg [2:0] o_cmd_code,
  output reg [15:0] o_cmd_data,
  output reg o_err_valid,
  output reg [2:0] o_err_code
);
  initial {o_cmd_valid, o_cmd_code, o_cmd_data, o_err_valid, o_err_code} = 0;
  // One command word, changed at the falling edge, held across one sampling edge
  task cmd(input [2:0] code, input [15:0] data);
    begin
      @(negedge i_sys_clk);
      o_cmd_valid = 1'b1;
      o_cmd_code = code;
      o_cmd_data = data & 16'h01FF;
      o_err_valid = 1'b0;
    end
  endtask
  // Parser error pulse
  task err(input [2:0] code);
    begin
      @(negedge i_sys_clk);
      o_cmd_valid = 1'b0;
      o_err_valid = 1'b1;
      o_err_code = code;
    end
  endtask
  // Idle cycle; data scrambled so stale words are never trusted
  task idle;
    begin
      @(negedge i_sys_clk);
      o_cmd_valid = 1'b0;
      o_err_valid = 1'b0;
      o_cmd_data = ~o_cmd_data;
    end
  endtask
endmodule // qsf_host

// File: bench/tb.sv
// Self-checking bench for the questionable status filter
`timescale 1ns/1ps
module tb;
  reg i_sys_clk = 0;
  reg i_reset_n = 0;
  reg i_ques_srq_enable = 1;
  reg [8:0] flt = 0; // Fault pins, bit order as in the status word
  wire cv, ev;
  wire [2:0] cc, ec;
  wire [15:0] cd, o_rsp_data;
  wire o_rsp_valid, o_ques_summary;
  integer miscompares = 0, n_tests = 0, cyc = 0, seed = 33501, k;
  reg [15:0] q[$]; // Expected answers, oldest first
  reg [8:0] fv, rv;
  initial forever #50 i_sys_clk = ~i_sys_clk;
  qsf_host i_qsf_host (.i_sys_clk(i_sys_clk), .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_data(cd),
    .o_err_valid(ev), .o_err_code(ec));
  qsf_top i_qsf_top (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_over_voltage_fault(flt[8]),
    .i_line_input_fault(flt[7]), .i_over_current_fault(flt[6]), .i_fan_fault(flt[5]),
    .i_output_short_fault(flt[4]), .i_over_temp_fault(flt[3]), .i_over_power_fault(flt[2]),
    .i_inner_dcdc_stage_fault(flt[1]), .i_inner_adc_stage_fault(flt[0]), .i_cmd_valid(cv),
    .i_cmd_code(cc), .i_cmd_data(cd), .i_err_valid(ev), .i_err_code(ec),
    .i_ques_srq_enable(i_ques_srq_enable), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_ques_summary(o_ques_summary));
  // Compare one value and count it
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_tests++;
      if (seen !== exp) begin
        miscompares++;
        $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  // Issue a read and note the answer it should bring
  task rd(input [2:0] code, input [15:0] exp);
    begin
      i_qsf_host.cmd(code, 16'h0000);
      q.push_back(exp);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Answers stand one cycle, so look mid-cycle
  always @(negedge i_sys_clk) if (o_rsp_valid === 1'b1) chk(o_rsp_data, q.pop_front());
  // Hang guard, far above the fifty or so cycles needed
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    #200 i_reset_n = 1;
    rd(3'h6, 16'h0000);
    rd(3'h0, 16'h0000);
    $display("test reset done");
    fv = $random(seed);
    rv = $random(seed);
    i_qsf_host.cmd(3'h2, fv);
    rd(3'h3, {7'h00, fv});
    i_qsf_host.cmd(3'h4, rv);
    rd(3'h5, {7'h00, rv});
    $display("test filters done");
    // Bit 8 stays zero in both filters, so it must never latch
    i_qsf_host.cmd(3'h2, 16'h00AA);
    i_qsf_host.cmd(3'h4, 16'h0055);
    i_qsf_host.idle;
    flt = 9'h1FF;
    repeat (4) i_qsf_host.idle;
    chk(o_ques_summary, 1);
    rd(3'h0, 16'h01FF);
    rd(3'h1, 16'h0055);
    i_qsf_host.idle;
    i_ques_srq_enable = 0;
    flt = 9'h000;
    repeat (4) i_qsf_host.idle;
    chk(o_ques_summary, 0);
    rd(3'h1, 16'h00AA);
    rd(3'h1, 16'h0000);
    i_ques_srq_enable = 1;
    // Random pattern checks pin to bit mapping; only rising-armed bits latch
    flt = $random(seed);
    repeat (3) i_qsf_host.idle;
    rd(3'h0, {7'h00, flt});
    rd(3'h1, {7'h00, flt & 9'h055});
    flt = 9'h000;
    $display("test events done");
    for (k = 1; k <= 4; k++) begin
      i_qsf_host.err(k[2:0]);
      rd(3'h6, k[15:0]);
      rd(3'h6, 16'h0000);
    end
    i_qsf_host.err(3'h1);
    i_qsf_host.err(3'h2);
    rd(3'h6, 16'h0003);
    $display("test errors done");
    // Reset in mid-run must drop a pending error
    i_qsf_host.err(3'h4);
    i_qsf_host.idle;
    i_reset_n = 0;
    repeat (2) i_qsf_host.idle;
    i_reset_n = 1;
    rd(3'h6, 16'h0000);
    repeat (3) i_qsf_host.idle;
    chk(q.size(), 0);
    $display("test reset again done");
    test_done;
  end
endmodule // tb
